// ===== shared/print_path_pkg.sv
// Shared constants for the terminal print-character path and its register bus
package print_path_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] MODE_OFF = 8'h04;
  localparam logic [7:0] LOAD_OFF = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h0C;
  localparam logic [7:0] PCHR_OFF = 8'h10;
  localparam logic [7:0] ICHR_OFF = 8'h14;
  localparam logic [7:0] CHK_OFF = 8'h18;
  // Mode register field positions
  localparam int MODE_ENTER_BIT = 0;
  localparam int MODE_RECV_BIT = 1;
  localparam int MODE_BPRINT_BIT = 2;
  localparam int MODE_COMM_BIT = 3;
  localparam int MODE_TEXT_BIT = 4;
  localparam int MODE_RXBUF_BIT = 5;
  localparam int MODE_BUFMODEL_BIT = 6;
  localparam int MODE_ANSWER_BIT = 7;
  localparam int MODE_RECCHK_BIT = 8;
  // Control register strobe positions
  localparam int CTRL_GEN_BIT = 0;
  localparam int CTRL_REPLY1_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int CTRL_ERR_BIT = 3;
  localparam int CTRL_XFER_BIT = 4;
  localparam int CTRL_NEG_BIT = 5;
  // Character bit positions (1,2,4,8,A,B,C)
  localparam int CH_1 = 0;
  localparam int CH_2 = 1;
  localparam int CH_4 = 2;
  localparam int CH_8 = 3;
  localparam int CH_A = 4;
  localparam int CH_B = 5;
  localparam int CH_C = 6;
  localparam int CHAR_W = 7;
  // Fixed character codes
  localparam logic [6:0] STOP_CODE = 7'h4F;
  localparam logic [6:0] NEG_REPLY_CHAR = 7'h22;
  localparam logic [6:0] POS_REPLY_CHAR = 7'h31;
  localparam logic [6:0] SENSE_CHAR = 7'h15;
  // Function character codes (bit 8 and 4 set)
  localparam logic [6:0] FN_BACKSPACE = 7'h2E;
  localparam logic [6:0] FN_SPACE = 7'h0C;
  localparam logic [6:0] FN_RETURN = 7'h4D;
  localparam logic [6:0] FN_TAB = 7'h1E;
  localparam logic [6:0] FN_UPSHIFT = 7'h0E;
  localparam logic [6:0] FN_DOWNSHIFT = 7'h1F;
  localparam int FN_NUM = 6;
  // Reset values
  localparam logic [8:0] MODE_RST = 9'h000;
  localparam logic [6:0] CHAR_RST = 7'h00;
  // Timing: control oscillator and phase offset
  localparam int CORE_HZ = 20_000_000;
  localparam int OSC_HZ = 18_000;
  localparam int OSC_DIV = CORE_HZ / OSC_HZ;
  localparam int PHASE_GAP_NS = 25_000;
  localparam int CLK_NS = 50;
  localparam int PHASE_GAP_CYC = PHASE_GAP_NS / CLK_NS;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== design/print_char_path.sv
// Character path between the serial register chain and the typewriter printer
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Function
// R01: Control characters except stop code load straight into the intermediate register.
// R02: Answerback negative-reply bit request waits until first reply character is done.
// R03: Sense characters load through the first-reply load line, not generate.
// R04: Control-character generate is delayed one character time.
// R05: Basic model: print register holds received characters; unused for sending.
// R06: Print register has seven latches, cleared before every new load.
// R07: Latches load from intermediate register only under load pulse without error block.
// R08: Record-check error blocks load and forces the low bit, typing a dash.
// R09: Buffered model loads from intermediate on receive, printer contacts on enter strobe.
// R10: Serial register is freed once the character reaches the print register.
// R11: Buffer print shifts the stored character in one bit at a time.
// R12: Enter end on bid key generates the stop code into the register for storage.
// R13: Bits 8 and 4 both set mean function; otherwise printable.
// R14: Print-out gate needs full register and no printer cycle; gates both decodes.
// R15: Print decode maps the character to tilt/rotate magnets, starting a cycle.
// R16: Function decode recognises six functions, one magnet each.
// R17: Print-out gate drops when a printer operation begins.
// R18: Strobe trigger one clipped by phase one, gated by enter; two follows 25 us later.
// R19: Printer-cycle latch follows the cycle contact exactly.
// R20: Check enable in buffer print and comm, or text receive unbuffered.
// R21: Each cycle copies the printed character into check register; contacts adjust it.
// R22: Printer closes cycle contact before strobe and opens it after strobe.
// R23: Two phase pulses come from a free-running control oscillator.
// R24: Printer contacts are synchronised to the control phases before use.
module print_char_path
  import print_path_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [6:0] I_SERIAL_CHAR,
  input wire logic I_MEMORY_BUFFER,
  input wire logic [6:0] I_TRANSMIT_CONTACTS,
  input wire logic I_PRINTER_CYCLE_CONTACT,
  input wire logic I_STROBE_CONTACT,
  output logic [6:0] O_INTERMEDIATE_CHAR_REG,
  output logic [6:0] O_PRINT_CHAR_REG,
  output logic [6:0] O_PRINT_MAGNETS,
  output logic [5:0] O_FUNCTION_MAGNETS,
  output logic O_SERIAL_FREE,
  output logic O_CLOCK_PHASE_ONE,
  output logic O_CLOCK_PHASE_TWO,
  output logic O_STORE_STOP_WRITE
);
  // ----------------------------------------------------------------
  // Control oscillator and phase pulses
  // ----------------------------------------------------------------
  logic [11:0] osc_cnt_r;
  logic [11:0] gap_cnt_r;
  logic gap_run_r;
  logic clock_phase_one;
  logic clock_phase_two;
  assign clock_phase_one = (osc_cnt_r == 12'(OSC_DIV - 1)); // see R23
  assign clock_phase_two = gap_run_r && (gap_cnt_r == 12'(PHASE_GAP_CYC - 1));
  // Free-running; phase two trails phase one by the fixed gap
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      osc_cnt_r <= 12'h000;
      gap_cnt_r <= 12'h000;
      gap_run_r <= 1'b0;
    end else begin
      osc_cnt_r <= clock_phase_one ? 12'h000 : osc_cnt_r + 12'h001; // see R23
      if (clock_phase_one) begin
        gap_run_r <= 1'b1;
        gap_cnt_r <= 12'h000;
      end else if (clock_phase_two) begin
        gap_run_r <= 1'b0;
      end else if (gap_run_r) begin
        gap_cnt_r <= gap_cnt_r + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bus (AXI4-Lite slave)
  // ----------------------------------------------------------------
  logic [7:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic w_held_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [8:0] mode_r;
  logic [6:0] load_char_r;
  logic wr_fire;
  logic wr_known;
  logic rd_fire;
  logic rd_known;
  logic [31:0] rd_mux;
  logic [6:0] ctrl_pulse;
  assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY = !w_held_r && !bvalid_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign wr_known = (awaddr_r == CTRL_OFF) || (awaddr_r == MODE_OFF) || (awaddr_r == LOAD_OFF);
  assign ctrl_pulse = (wr_fire && awaddr_r == CTRL_OFF) ? wdata_r[6:0] : 7'h00;
  assign rd_fire = S_AXI_ARVALID && !rvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  // Address and data are captured independently, in either order
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_r <= 1'b1;
        wdata_r <= S_AXI_WDATA & {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
                                  {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  // Software settings: mode bits and the character presented for generation
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      mode_r <= MODE_RST;
      load_char_r <= CHAR_RST;
    end else if (wr_fire && awaddr_r == MODE_OFF) begin
      mode_r <= wdata_r[8:0];
    end else if (wr_fire && awaddr_r == LOAD_OFF) begin
      load_char_r <= wdata_r[6:0];
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and contact synchroniser
  // ----------------------------------------------------------------
  logic enter_mode;
  logic recv_mode;
  logic bprint_mode;
  logic buffered_model;
  logic check_enable;
  assign enter_mode = mode_r[MODE_ENTER_BIT];
  assign recv_mode = mode_r[MODE_RECV_BIT];
  assign bprint_mode = mode_r[MODE_BPRINT_BIT];
  assign buffered_model = mode_r[MODE_BUFMODEL_BIT];
  assign check_enable = (bprint_mode && mode_r[MODE_COMM_BIT]) ||
                        (recv_mode && mode_r[MODE_TEXT_BIT] && !mode_r[MODE_RXBUF_BIT]); // see R20
  logic [1:0] cyc_sync_r;
  logic [1:0] stb_sync_r;

  // ----------------------------------------------------------------
  // Printer timing latches and strobe triggers
  // ----------------------------------------------------------------
  logic printer_cycle_r;
  logic strobe_one_r;
  logic strobe_two_r;
  logic check_strobe_r;
  logic strobe_rise;
  logic strobe_two_d_r;
  // Contacts cross two synchroniser stages; only the second feeds the latches
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      cyc_sync_r <= 2'b00;
      stb_sync_r <= 2'b00;
      printer_cycle_r <= 1'b0;
      strobe_one_r <= 1'b0;
      strobe_two_r <= 1'b0;
      strobe_two_d_r <= 1'b0;
      check_strobe_r <= 1'b0;
    end else begin
      cyc_sync_r <= {cyc_sync_r[0], I_PRINTER_CYCLE_CONTACT}; // see R24
      stb_sync_r <= {stb_sync_r[0], I_STROBE_CONTACT}; // see R24
      printer_cycle_r <= cyc_sync_r[1]; // see R19, R22
      if (clock_phase_one) begin
        strobe_one_r <= stb_sync_r[1] && enter_mode; // see R18
      end
      if (clock_phase_two) begin
        strobe_two_r <= strobe_one_r; // see R18
      end
      strobe_two_d_r <= strobe_two_r;
      check_strobe_r <= stb_sync_r[1] && check_enable; // see R20
    end
  end
  assign strobe_rise = strobe_two_r && !strobe_two_d_r;

  // ----------------------------------------------------------------
  // Intermediate register and answerback sequencing
  // ----------------------------------------------------------------
  logic [6:0] inter_r;
  logic gen_pend_r;
  logic neg_pend_r;
  logic reply1_done_r;
  logic neg_reply_bit_request;
  logic ctrl_char_generate;
  assign neg_reply_bit_request = mode_r[MODE_ANSWER_BIT] && ctrl_pulse[CTRL_NEG_BIT]; // see R02
  assign ctrl_char_generate = gen_pend_r && clock_phase_one;
  // Generated characters wait one character time so a reply can go first
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      inter_r <= CHAR_RST;
      gen_pend_r <= 1'b0;
      neg_pend_r <= 1'b0;
      reply1_done_r <= 1'b0;
    end else begin
      if (ctrl_pulse[CTRL_GEN_BIT]) begin
        gen_pend_r <= 1'b1; // see R04
      end else if (ctrl_char_generate) begin
        gen_pend_r <= 1'b0;
        inter_r <= load_char_r; // see R01, R04
      end
      if (ctrl_pulse[CTRL_REPLY1_BIT]) begin
        inter_r <= SENSE_CHAR; // see R03
        reply1_done_r <= 1'b1;
      end else if (neg_pend_r && reply1_done_r && clock_phase_one) begin
        inter_r <= NEG_REPLY_CHAR; // see R02
        neg_pend_r <= 1'b0;
        reply1_done_r <= 1'b0;
      end
      if (neg_reply_bit_request) begin
        neg_pend_r <= 1'b1; // see R02
      end
      if (recv_mode && ctrl_pulse[CTRL_XFER_BIT]) begin
        inter_r <= I_SERIAL_CHAR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Print-character register
  // ----------------------------------------------------------------
  logic [6:0] pchr_r;
  logic full_r;
  logic xfer_pend_r;
  logic [2:0] scan_cnt_r;
  logic scan_run_r;
  logic print_reg_load_pulse;
  logic print_reg_clear;
  logic print_reg_error_block;
  logic enter_load;
  logic stop_load;
  logic print_out_gate;
  assign print_reg_error_block = mode_r[MODE_RECCHK_BIT] && ctrl_pulse[CTRL_ERR_BIT]; // see R08
  assign print_reg_load_pulse = xfer_pend_r && !full_r && clock_phase_two;
  assign enter_load = buffered_model && enter_mode && strobe_rise; // see R09
  assign stop_load = buffered_model && enter_mode && ctrl_pulse[CTRL_STOP_BIT]; // see R12
  assign print_reg_clear = print_reg_load_pulse || enter_load || stop_load ||
                           (bprint_mode && ctrl_pulse[CTRL_XFER_BIT]); // see R06
  // Receive loads queue until the register empties; serial side stays busy until the load
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      pchr_r <= CHAR_RST;
      full_r <= 1'b0;
      xfer_pend_r <= 1'b0;
      scan_cnt_r <= 3'd0;
      scan_run_r <= 1'b0;
    end else begin
      if (recv_mode && ctrl_pulse[CTRL_XFER_BIT] && !print_reg_error_block) begin
        xfer_pend_r <= 1'b1; // see R05, R09
      end else if (print_reg_load_pulse || print_reg_error_block) begin
        xfer_pend_r <= 1'b0; // see R08
      end
      if (print_reg_error_block) begin
        pchr_r <= CHAR_RST | 7'(1 << CH_1); // see R08
        full_r <= 1'b1;
      end else if (print_reg_load_pulse) begin
        pchr_r <= inter_r; // see R06, R07
        full_r <= 1'b1;
      end else if (enter_load) begin
        pchr_r <= I_TRANSMIT_CONTACTS; // see R09
        full_r <= 1'b1;
      end else if (stop_load) begin
        pchr_r <= STOP_CODE; // see R12
        full_r <= 1'b1;
      end else if (bprint_mode && ctrl_pulse[CTRL_XFER_BIT]) begin
        pchr_r <= CHAR_RST; // see R06
        full_r <= 1'b0;
        scan_run_r <= 1'b1;
        scan_cnt_r <= 3'd0;
      end else if (scan_run_r) begin
        pchr_r[scan_cnt_r] <= I_MEMORY_BUFFER; // see R11
        scan_cnt_r <= scan_cnt_r + 3'd1;
        if (scan_cnt_r == 3'(CHAR_W - 1)) begin
          scan_run_r <= 1'b0;
          full_r <= 1'b1;
        end
      end else if (print_out_gate || (full_r && enter_mode)) begin
        full_r <= 1'b0;
      end
    end
  end
  assign O_SERIAL_FREE = !xfer_pend_r; // see R10
  assign O_STORE_STOP_WRITE = full_r && enter_mode && (pchr_r == STOP_CODE); // see R12

  // ----------------------------------------------------------------
  // Print and function decode
  // ----------------------------------------------------------------
  logic is_function;
  logic [6:0] magnets_nxt;
  logic [5:0] fn_nxt;
  logic [6:0] print_mag_r;
  logic [5:0] fn_mag_r;
  logic [6:0] check_r;
  assign is_function = pchr_r[CH_8] && pchr_r[CH_4]; // see R13
  assign print_out_gate = full_r && !printer_cycle_r && !enter_mode; // see R14, R17
  assign magnets_nxt = (print_out_gate && !is_function) ?
                       {pchr_r[CH_B], pchr_r[CH_A], pchr_r[CH_8] ^ pchr_r[CH_1],
                        pchr_r[CH_4], pchr_r[CH_2], pchr_r[CH_1], 1'b1} : 7'h00; // see R15
  assign fn_nxt = !(print_out_gate && is_function) ? 6'h00 :
                  {pchr_r == FN_DOWNSHIFT, pchr_r == FN_UPSHIFT, pchr_r == FN_TAB,
                   pchr_r == FN_RETURN, pchr_r == FN_SPACE, pchr_r == FN_BACKSPACE}; // see R16
  // Magnets held until the cycle contact makes, then released
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      print_mag_r <= 7'h00;
      fn_mag_r <= 6'h00;
      check_r <= CHAR_RST;
    end else begin
      if (print_out_gate) begin
        print_mag_r <= magnets_nxt;
        fn_mag_r <= fn_nxt;
        check_r <= pchr_r; // see R21
      end else if (printer_cycle_r) begin
        print_mag_r <= 7'h00; // see R17
        fn_mag_r <= 6'h00;
      end
      if (check_strobe_r) begin
        check_r <= check_r ^ I_TRANSMIT_CONTACTS; // see R21
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path and outputs
  // ----------------------------------------------------------------
  assign rd_known = (S_AXI_ARADDR == CTRL_OFF) || (S_AXI_ARADDR == MODE_OFF) ||
                    (S_AXI_ARADDR == LOAD_OFF) || (S_AXI_ARADDR == STAT_OFF) ||
                    (S_AXI_ARADDR == PCHR_OFF) || (S_AXI_ARADDR == ICHR_OFF) ||
                    (S_AXI_ARADDR == CHK_OFF);
  assign rd_mux = (S_AXI_ARADDR == MODE_OFF) ? {23'h0, mode_r} :
                  (S_AXI_ARADDR == LOAD_OFF) ? {25'h0, load_char_r} :
                  (S_AXI_ARADDR == STAT_OFF) ? {24'h0, printer_cycle_r, check_strobe_r,
                    strobe_two_r, gen_pend_r, neg_pend_r, xfer_pend_r, is_function, full_r} :
                  (S_AXI_ARADDR == PCHR_OFF) ? {25'h0, pchr_r} :
                  (S_AXI_ARADDR == ICHR_OFF) ? {25'h0, inter_r} :
                  (S_AXI_ARADDR == CHK_OFF) ? {25'h0, check_r} : 32'h0000_0000;
  // Read answers one cycle after the address is taken
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end
  assign O_INTERMEDIATE_CHAR_REG = inter_r;
  assign O_PRINT_CHAR_REG = pchr_r;
  assign O_PRINT_MAGNETS = print_mag_r;
  assign O_FUNCTION_MAGNETS = fn_mag_r;
  assign O_CLOCK_PHASE_ONE = clock_phase_one;
  assign O_CLOCK_PHASE_TWO = clock_phase_two;
endmodule
`default_nettype wire

// ===== dv/print_path_props.sv
// Concurrent checks on the ports of the print-character path
`timescale 1ns/100ps
`default_nettype none
module print_path_props
  import print_path_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_PRINTER_CYCLE_CONTACT,
  input wire logic [6:0] O_PRINT_CHAR_REG,
  input wire logic [6:0] O_PRINT_MAGNETS,
  input wire logic [5:0] O_FUNCTION_MAGNETS,
  input wire logic O_CLOCK_PHASE_ONE,
  input wire logic O_CLOCK_PHASE_TWO,
  input wire logic O_STORE_STOP_WRITE
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);
  int gap_r;
  logic seen_r;
  // Cycles since the last phase-one pulse; the first pulse has no reference
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      gap_r <= 0;
      seen_r <= 1'h0;
    end else begin
      gap_r <= O_CLOCK_PHASE_ONE ? 0 : gap_r + 1;
      seen_r <= seen_r | O_CLOCK_PHASE_ONE;
    end
  end
  a_phase_gap: assert property (O_CLOCK_PHASE_ONE |-> ##[500:500] O_CLOCK_PHASE_TWO)
    else $error("phase two not 500 cycles after phase one");
  a_phase_period: assert property (O_CLOCK_PHASE_ONE && seen_r |-> gap_r == OSC_DIV - 1)
    else $error("phase one period wrong");
  a_fn_onehot: assert property ($onehot0(O_FUNCTION_MAGNETS) && !((|O_FUNCTION_MAGNETS) && (|O_PRINT_MAGNETS)))
    else $error("function magnets not single");
  a_fn_needs_84: assert property ($rose(|O_FUNCTION_MAGNETS) |-> $past(O_PRINT_CHAR_REG[CH_8] && O_PRINT_CHAR_REG[CH_4]))
    else $error("function decode without 8-4");
  a_print_not_fn: assert property ($rose(|O_PRINT_MAGNETS) |-> !$past(O_PRINT_CHAR_REG[CH_8] && O_PRINT_CHAR_REG[CH_4]))
    else $error("print decode on function char");
  // A contact closed for four cycles has surely reached the cycle latch
  a_decode_blocked: assert property ($past(I_PRINTER_CYCLE_CONTACT, 2) && $past(I_PRINTER_CYCLE_CONTACT, 3) && $past(I_PRINTER_CYCLE_CONTACT, 4) && $past(I_PRINTER_CYCLE_CONTACT, 5) |-> !$rose(|O_PRINT_MAGNETS) && !$rose(|O_FUNCTION_MAGNETS))
    else $error("decode during printer cycle");
  a_magnet_drop: assert property ($rose(I_PRINTER_CYCLE_CONTACT) |-> ##[1:5] (O_PRINT_MAGNETS == 7'h00 && O_FUNCTION_MAGNETS == 6'h00))
    else $error("magnets stay after cycle start");
  a_stop_write: assert property (O_STORE_STOP_WRITE |-> O_PRINT_CHAR_REG == STOP_CODE ##1 !O_STORE_STOP_WRITE)
    else $error("stop write without stop code");
  c_print: cover property ($rose(|O_PRINT_MAGNETS));
  c_func: cover property ($rose(|O_FUNCTION_MAGNETS));
  c_stop: cover property (O_STORE_STOP_WRITE);
endmodule
bind print_char_path print_path_props u_props (.I_CORE_CLK, .I_RST_N, .I_PRINTER_CYCLE_CONTACT,
  .O_PRINT_CHAR_REG, .O_PRINT_MAGNETS, .O_FUNCTION_MAGNETS, .O_CLOCK_PHASE_ONE,
  .O_CLOCK_PHASE_TWO, .O_STORE_STOP_WRITE);
`default_nettype wire

// ===== dv/print_mech_model.sv
// Behavioural model of the typewriter printer contacts
`timescale 1ns/100ps
`default_nettype none
module print_mech_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] mag,
  input wire logic [5:0] fmag,
  output logic cyc,
  output logic stb,
  output logic [6:0] tc
);
  logic [5:0] t_r;
  logic slow_r;
  logic [6:0] ch_r;
  logic [6:0] wig_r;
  // One mechanical cycle per pick; prompt and slow closures alternate
  always_ff @(posedge clk) begin
    wig_r <= wig_r + 7'h01;
    if (!rst_n) begin
      t_r <= 6'h00;
      slow_r <= 1'h0;
      ch_r <= 7'h00;
      wig_r <= 7'h00;
    end else if (t_r != 6'h00) begin
      t_r <= (t_r == 6'h28) ? 6'h00 : t_r + 6'h01;
    end else if ((|mag) || (|fmag)) begin
      t_r <= 6'h01;
      slow_r <= !slow_r;
      ch_r <= mag;
    end
  end
  // Cycle contact makes before strobe and breaks after it, so contacts settle
  assign cyc = t_r >= (slow_r ? 6'h0A : 6'h02) && t_r <= 6'h24;
  assign stb = t_r >= (slow_r ? 6'h0E : 6'h06) && t_r <= 6'h1E;
  // Outside strobe the contacts float, showing the held code only when wig_r is 7'h7F
  assign tc = stb ? ch_r : ~ch_r ^ wig_r;
endmodule
`default_nettype wire

// ===== dv/print_char_path_bench.sv
// Self-checking bench for the print-character path
`timescale 1ns/100ps
`default_nettype none
module print_char_path_bench
  import print_path_pkg::*;
;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] ws = 4'h0;
  logic [6:0] ser = 7'h00;
  logic awr, wr_r, bv, arr, rv, sfree, ph1, ph2, stw, cyc, stb;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  logic [6:0] ich, pch, pm, tc;
  logic [5:0] fm;
  int failures = 0;
  int n_tests = 0;
  logic [6:0] codes [7] = '{7'h31, FN_BACKSPACE, FN_SPACE, FN_RETURN, FN_TAB, FN_UPSHIFT,
    FN_DOWNSHIFT};
  always #25 clk = ~clk;
  print_char_path uut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy),
    .I_SERIAL_CHAR(ser), .I_MEMORY_BUFFER(1'h0), .I_TRANSMIT_CONTACTS(tc),
    .I_PRINTER_CYCLE_CONTACT(cyc), .I_STROBE_CONTACT(stb), .O_INTERMEDIATE_CHAR_REG(ich),
    .O_PRINT_CHAR_REG(pch), .O_PRINT_MAGNETS(pm), .O_FUNCTION_MAGNETS(fm),
    .O_SERIAL_FREE(sfree), .O_CLOCK_PHASE_ONE(ph1), .O_CLOCK_PHASE_TWO(ph2),
    .O_STORE_STOP_WRITE(stw));
  print_mech_model printer (.clk(clk), .rst_n(rst_n), .mag(pm), .fmag(fm), .cyc(cyc),
    .stb(stb), .tc(tc));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      failures++;
    end
  endtask
  // Bus writes hold each channel until taken; bready stays up until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd, got;
    ad = 1'h0;
    dd = 1'h0;
    got = 1'h0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= 4'hF;
    awv <= 1'h1;
    wv <= 1'h1;
    brdy <= 1'h1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge clk);
      if (!ad && awr) begin
        ad = 1'h1;
        awv <= 1'h0;
      end
      if (!dd && wr_r) begin
        dd = 1'h1;
        wv <= 1'h0;
      end
      if (bv) begin
        got = 1'h1;
        brdy <= 1'h0;
        chk("bresp", 32'(er), 32'(br));
      end
    end
    if (!got) begin
      chk("bvalid", 32'h1, 32'h0);
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ad, got;
    ad = 1'h0;
    got = 1'h0;
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rrdy <= 1'h1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge clk);
      if (!ad && arr) begin
        ad = 1'h1;
        arv <= 1'h0;
      end
      if (rv) begin
        got = 1'h1;
        rrdy <= 1'h0;
        chk("rresp", 32'(er), 32'(rr));
        if (er == RESP_OKAY) chk("rdata", e, rdat);
      end
    end
    if (!got) begin
      chk("rvalid", 32'h1, 32'h0);
      tally_and_finish();
    end
  endtask
  // Bounded wait on an output; running out is a mismatch and ends the run
  task automatic wait_for(input string nm, input int sel, input logic [6:0] v, input int lim);
    logic [6:0] s;
    s = 7'h00;
    for (int n = 0; n < lim; n++) begin
      @(posedge clk);
      s = sel == 0 ? ich : sel == 1 ? pch : sel == 2 ? {1'h0, fm} : sel == 3 ? {6'h00, stw}
        : {6'h00, |pm};
      if (s === v) break;
    end
    chk(nm, 32'(v), 32'(s));
    if (s !== v) tally_and_finish();
  endtask
  // Main sequence: registers, generated characters, receive, error, stop code
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rd(MODE_OFF, 32'h0000_0000, RESP_OKAY);
    rd(PCHR_OFF, 32'h0000_0000, RESP_OKAY);
    rd(8'h1C, 32'h0000_0000, RESP_SLVERR);
    wr(STAT_OFF, 32'h0000_0000, RESP_SLVERR);
    wr(LOAD_OFF, 32'(POS_REPLY_CHAR), RESP_OKAY);
    wr(CTRL_OFF, 32'h1 << CTRL_GEN_BIT, RESP_OKAY);
    wait_for("ich gen", 0, POS_REPLY_CHAR, 3000);
    wr(MODE_OFF, 32'h1 << MODE_ANSWER_BIT, RESP_OKAY);
    wr(CTRL_OFF, (32'h1 << CTRL_REPLY1_BIT) | (32'h1 << CTRL_NEG_BIT), RESP_OKAY);
    wait_for("ich sense", 0, SENSE_CHAR, 3000);
    wait_for("ich neg", 0, NEG_REPLY_CHAR, 3000);
    wr(MODE_OFF, 32'h1 << MODE_RECV_BIT, RESP_OKAY);
    foreach (codes[i]) begin
      ser <= codes[i];
      wr(CTRL_OFF, 32'h1 << CTRL_XFER_BIT, RESP_OKAY);
      wait_for("pchr", 1, codes[i], 5000);
      chk("serial free", 32'h1, 32'(sfree));
      if (i == 0) wait_for("print mag", 4, 7'h01, 100);
      else wait_for("fn mag", 2, 7'h01 << (i - 1), 100);
    end
    wr(MODE_OFF, (32'h1 << MODE_RECV_BIT) | (32'h1 << MODE_RECCHK_BIT), RESP_OKAY);
    ser <= POS_REPLY_CHAR;
    wr(CTRL_OFF, (32'h1 << CTRL_ERR_BIT) | (32'h1 << CTRL_XFER_BIT), RESP_OKAY);
    wait_for("pchr dash", 1, 7'h01, 5000);
    repeat (1200) @(posedge clk);
    chk("pchr held", 32'h01, 32'(pch));
    wr(MODE_OFF, (32'h1 << MODE_ENTER_BIT) | (32'h1 << MODE_BUFMODEL_BIT), RESP_OKAY);
    wr(CTRL_OFF, 32'h1 << CTRL_STOP_BIT, RESP_OKAY);
    chk("stop write", 32'h1, 32'(stw));
    chk("pchr stop", 32'(STOP_CODE), 32'(pch));
    tally_and_finish();
  end
endmodule
`default_nettype wire
